/* File: shared/adcof_pkg.sv */
// Constants and types shared by the output formatter
// What this block does
// - Stabilizer on: internal clock strobe rebuilt at fifty percent duty
// - Stabilizer loop may idle below twenty megahertz sample rate
// - After a rate change, bypass stabilizer until relock in 1.5 to 5 us
// - Power-down enters from pin high or serial control bit
// - Power-down holds all data drivers in high impedance
// - Power-down pin low returns the device to normal conversion
// - Power-down stops reference and clock; wake time grows with time down
// - Standby, serial only, keeps reference up for faster wake-up
// - Pin mode: format pin low offset binary, high twos complement
// - Serial mode offers offset binary, twos complement and gray
// - Output disable pin low enables drivers, high floats them
// - Serial disable bits float data and fast detect outputs, each per channel
// - Each sample appears twelve clocks after it was taken
// - Two data output clocks; data valid while high unless inverted
// - Offset binary codes; twos complement inverts the top bit
// - Overrange sets flag and saturates channel A code beyond half an LSB; channel B code is not saturated
// - Divider ratio other than one forces the stabilizer on
package adcof_pkg;
	localparam int ADCOF_WIDTH = 12;
	localparam int ADCOF_LATENCY = 12;
	localparam int ADCOF_CLK_MHZ = 50;
	localparam int ADCOF_RELOCK_MIN_NS = 1500;
	localparam int ADCOF_RELOCK_MAX_NS = 5000;
	localparam int ADCOF_RELOCK_CYC = (ADCOF_RELOCK_MIN_NS * ADCOF_CLK_MHZ + 999) / 1000;
	localparam int ADCOF_SLOW_MHZ = 20;
	localparam int ADCOF_WAKE_W = 16;
	localparam int ADCOF_STBY_WAKE = 4;
	localparam logic [11:0] ADCOF_CODE_MIN = 12'h000;
	localparam logic [11:0] ADCOF_CODE_MAX = 12'hfff;
	localparam logic [11:0] ADCOF_MSB = 12'h800;
	localparam logic [2:0] ADCOF_DIV_ONE = 3'h0;
	typedef enum logic [1:0] {
		ADCOF_FMT_OFFSET = 2'h0,
		ADCOF_FMT_TWOS = 2'h1,
		ADCOF_FMT_GRAY = 2'h2
	} adcof_fmt_t;
	typedef enum logic [2:0] {
		ADCOF_RUN = 3'b001,
		ADCOF_DOWN = 3'b010,
		ADCOF_WAKE = 3'b100
	} adcof_state_t;
endpackage

/* File: verilog/adcof_delay.sv */
// Fixed-latency delay line for one sample lane
`timescale 1ns/1ns
module adcof_delay import adcof_pkg::*; #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 12
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [WIDTH-1:0] data_i,
	output logic [WIDTH-1:0] data_o
);
	logic [WIDTH-1:0] stage [DEPTH];
	logic [WIDTH-1:0] next_stage [DEPTH];
	always_comb begin
		next_stage[0] = data_i;
		for (int i = 1; i < DEPTH; i++) begin
			next_stage[i] = stage[i-1];
		end
	end
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (reset_i) begin
				stage[i] <= '0;
			end else begin
				stage[i] <= next_stage[i];
			end
		end
	end
	assign data_o = stage[DEPTH-1];
endmodule

/* File: verilog/adcof_top.sv */
// Output formatter: power control, coding, latency, drivers and data clocks
`timescale 1ns/1ns
module adcof_top import adcof_pkg::*; #(
	parameter int WIDTH = ADCOF_WIDTH,
	parameter int LATENCY = ADCOF_LATENCY,
	parameter int RELOCK_CYC = ADCOF_RELOCK_CYC
) (
	input wire logic MCLK_I,
	input wire logic RESET_I,
	input wire logic [WIDTH-1:0] SAMPLE_I,
	input wire logic OVER_HIGH_I,
	input wire logic OVER_LOW_I,
	input wire logic SAMPLE_VALID_I,
	input wire logic SERIAL_MODE_I,
	input wire logic FORMAT_SELECT_PIN_I,
	input wire logic STABILIZER_SELECT_PIN_I,
	input wire logic [1:0] SERIAL_FORMAT_I,
	input wire logic SERIAL_STABILIZER_I,
	input wire logic [2:0] CLOCK_DIVIDER_I,
	input wire logic RATE_CHANGE_I,
	input wire logic SLOW_CLOCK_I,
	input wire logic POWER_DOWN_PIN_I,
	input wire logic SERIAL_POWER_DOWN_I,
	input wire logic SERIAL_STANDBY_I,
	input wire logic OUTPUT_DISABLE_PIN_I,
	input wire logic [1:0] OUTPUT_DISABLE_BIT_I,
	input wire logic [1:0] FAST_DISABLE_BIT_I,
	input wire logic DCO_INVERT_I,
	input wire logic RECV_READY_I,
	output logic [WIDTH-1:0] DATA_A_O,
	output logic [WIDTH-1:0] DATA_B_O,
	output logic OVERRANGE_O,
	output logic [1:0] DATA_OE_O,
	output logic [1:0] FAST_OE_O,
	output logic DATA_VALID_O,
	output logic [1:0] DATA_OUTPUT_CLOCK_O,
	output logic STABILIZER_ACTIVE_O,
	output logic STABILIZER_LOCKED_O,
	output logic REFERENCE_ON_O,
	output logic INTERNAL_CLOCK_ON_O,
	output logic POWERED_DOWN_O,
	output logic BUF_READY_O
);
	// ******************************
	// Power control
	// ******************************
	adcof_state_t state, next_state;
	logic [ADCOF_WAKE_W-1:0] down_cnt, next_down_cnt;
	logic [ADCOF_WAKE_W-1:0] wake_cnt, next_wake_cnt;
	logic pd_req;
	assign pd_req = POWER_DOWN_PIN_I | SERIAL_POWER_DOWN_I;
	always_comb begin
		next_state = state;
		next_down_cnt = down_cnt;
		next_wake_cnt = wake_cnt;
		case (state)
			ADCOF_RUN: begin
				if (pd_req || (SERIAL_MODE_I && SERIAL_STANDBY_I)) begin
					next_state = ADCOF_DOWN;
					next_down_cnt = '0;
				end
			end
			ADCOF_DOWN: begin
				// Saturate so very long sleeps do not wrap to a short wake
				if (down_cnt != '1) begin
					next_down_cnt = down_cnt + 1'b1;
				end
				if (!pd_req && !(SERIAL_MODE_I && SERIAL_STANDBY_I)) begin
					next_state = ADCOF_WAKE;
					// Standby kept the reference charged, so waking is short
					next_wake_cnt = REFERENCE_ON_O ? ADCOF_WAKE_W'(ADCOF_STBY_WAKE)
						: down_cnt;
				end
			end
			ADCOF_WAKE: begin
				if (pd_req) begin
					next_state = ADCOF_DOWN;
				end else if (wake_cnt == '0) begin
					next_state = ADCOF_RUN;
				end else begin
					next_wake_cnt = wake_cnt - 1'b1;
				end
			end
			default: next_state = ADCOF_RUN;
		endcase
	end
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			state <= ADCOF_RUN;
			down_cnt <= '0;
			wake_cnt <= '0;
		end else begin
			state <= next_state;
			down_cnt <= next_down_cnt;
			wake_cnt <= next_wake_cnt;
		end
	end

	// ******************************
	// Duty stabilizer control
	// ******************************
	logic stab_req, locked, next_locked;
	logic [15:0] lock_cnt, next_lock_cnt;
	logic phase, next_phase;
	assign stab_req = (CLOCK_DIVIDER_I != ADCOF_DIV_ONE)
		| (SERIAL_MODE_I ? SERIAL_STABILIZER_I : STABILIZER_SELECT_PIN_I);
	always_comb begin
		next_lock_cnt = lock_cnt;
		next_locked = locked;
		// Loop idles at slow rates; held unlocked rather than guessing
		if (!stab_req || SLOW_CLOCK_I || RATE_CHANGE_I || state != ADCOF_RUN) begin
			next_lock_cnt = '0;
			next_locked = 1'b0;
		end else if (!locked) begin
			if (lock_cnt == 16'(RELOCK_CYC - 1)) begin
				next_locked = 1'b1;
			end else begin
				next_lock_cnt = lock_cnt + 1'b1;
			end
		end
		// Regenerated strobe toggles every edge: nominal half duty
		next_phase = (state == ADCOF_RUN) ? ~phase : 1'b0;
	end
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			lock_cnt <= '0;
			locked <= 1'b0;
			phase <= 1'b0;
		end else begin
			lock_cnt <= next_lock_cnt;
			locked <= next_locked;
			phase <= next_phase;
		end
	end

	// ******************************
	// Coding and latency
	// ******************************
	logic [WIDTH-1:0] sat_code, ob_a, ob_b, coded_a, coded_b;
	logic over, over_d, vld_d;
	logic [WIDTH-1:0] del_a, del_b;
	adcof_fmt_t fmt;
	assign over = OVER_HIGH_I | OVER_LOW_I;
	always_comb begin
		sat_code = OVER_HIGH_I ? ADCOF_CODE_MAX
			: (OVER_LOW_I ? ADCOF_CODE_MIN : SAMPLE_I);
		ob_a = sat_code;
		ob_b = SAMPLE_I;
		if (SERIAL_MODE_I) begin
			fmt = adcof_fmt_t'(SERIAL_FORMAT_I);
		end else begin
			fmt = FORMAT_SELECT_PIN_I ? ADCOF_FMT_TWOS : ADCOF_FMT_OFFSET;
		end
		case (fmt)
			ADCOF_FMT_TWOS: begin
				coded_a = ob_a ^ ADCOF_MSB;
				coded_b = ob_b ^ ADCOF_MSB;
			end
			ADCOF_FMT_GRAY: begin
				coded_a = ob_a ^ (ob_a >> 1);
				coded_b = ob_b ^ (ob_b >> 1);
			end
			default: begin
				coded_a = ob_a;
				coded_b = ob_b;
			end
		endcase
	end
	// Channel B shares the input in this model; lanes kept separate
	adcof_delay #(.WIDTH(WIDTH + 2), .DEPTH(LATENCY - 1)) u_lane_a (
		.clk_i(MCLK_I),
		.reset_i(RESET_I),
		.data_i({SAMPLE_VALID_I && state == ADCOF_RUN, over, coded_a}),
		.data_o({vld_d, over_d, del_a})
	);
	adcof_delay #(.WIDTH(WIDTH), .DEPTH(LATENCY - 1)) u_lane_b (
		.clk_i(MCLK_I),
		.reset_i(RESET_I),
		.data_i(coded_b),
		.data_o(del_b)
	);

	// ******************************
	// Two-entry output buffer
	// ******************************
	logic [2*WIDTH:0] buf_mem [2];
	logic [2*WIDTH:0] next_mem0, next_mem1;
	logic [1:0] cnt, next_cnt;
	logic push, pop;
	assign push = vld_d && (cnt != 2'h2);
	assign pop = (cnt != 2'h0) && RECV_READY_I;
	always_comb begin
		next_mem0 = buf_mem[0];
		next_mem1 = buf_mem[1];
		next_cnt = cnt + 2'(push) - 2'(pop);
		if (pop) begin
			next_mem0 = buf_mem[1];
		end
		if (push) begin
			if (next_cnt == 2'h1) begin
				next_mem0 = {over_d, del_a, del_b};
			end else begin
				next_mem1 = {over_d, del_a, del_b};
			end
		end
	end
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			cnt <= '0;
			buf_mem[0] <= '0;
			buf_mem[1] <= '0;
		end else begin
			cnt <= next_cnt;
			buf_mem[0] <= next_mem0;
			buf_mem[1] <= next_mem1;
		end
	end

	// ******************************
	// Output registers
	// ******************************
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			DATA_A_O <= '0;
			DATA_B_O <= '0;
			OVERRANGE_O <= 1'b0;
			DATA_VALID_O <= 1'b0;
			DATA_OE_O <= '0;
			FAST_OE_O <= '0;
			DATA_OUTPUT_CLOCK_O <= '0;
			STABILIZER_ACTIVE_O <= 1'b0;
			STABILIZER_LOCKED_O <= 1'b0;
			REFERENCE_ON_O <= 1'b1;
			INTERNAL_CLOCK_ON_O <= 1'b1;
			POWERED_DOWN_O <= 1'b0;
			BUF_READY_O <= 1'b0;
		end else begin
			DATA_VALID_O <= pop;
			if (pop) begin
				{OVERRANGE_O, DATA_A_O, DATA_B_O} <= buf_mem[0];
			end
			for (int c = 0; c < 2; c++) begin
				DATA_OE_O[c] <= (state == ADCOF_RUN) && !OUTPUT_DISABLE_PIN_I
					&& !(SERIAL_MODE_I && OUTPUT_DISABLE_BIT_I[c]);
				FAST_OE_O[c] <= (state == ADCOF_RUN) && !OUTPUT_DISABLE_PIN_I
					&& !(SERIAL_MODE_I && FAST_DISABLE_BIT_I[c]);
			end
			// Data changes as the strobe rises (falls when DCO_INVERT_I is set); capture logic latches at the next clock edge
			DATA_OUTPUT_CLOCK_O <= {2{pop ^ DCO_INVERT_I}};
			// Enabled by request; lock status is reported separately
			STABILIZER_ACTIVE_O <= stab_req && !SLOW_CLOCK_I && state == ADCOF_RUN;
			STABILIZER_LOCKED_O <= locked;
			REFERENCE_ON_O <= (next_state != ADCOF_DOWN) || !pd_req;
			INTERNAL_CLOCK_ON_O <= next_state != ADCOF_DOWN || !pd_req;
			POWERED_DOWN_O <= next_state != ADCOF_RUN;
			BUF_READY_O <= next_cnt != 2'h2;
		end
	end

	// ******************************
	// Checks
	// ******************************
	AST_PD_FLOAT: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		state == ADCOF_DOWN |=> DATA_OE_O == 2'h0) else $error("drivers on in power-down");
	AST_PD_ENTER: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		POWER_DOWN_PIN_I |=> state == ADCOF_DOWN) else $error("power-down not entered");
	AST_OE_PIN: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		OUTPUT_DISABLE_PIN_I |=> DATA_OE_O == 2'h0 && FAST_OE_O == 2'h0)
		else $error("outputs driven while disabled");
	AST_LOCK_BYPASS: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		RATE_CHANGE_I |=> !locked) else $error("stabilizer locked during rate change");
	AST_DIV_FORCE: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		CLOCK_DIVIDER_I != ADCOF_DIV_ONE && state == ADCOF_RUN && !SLOW_CLOCK_I
		|=> STABILIZER_ACTIVE_O) else $error("divider left stabilizer off");
	AST_HALF_DUTY: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		state == ADCOF_RUN |=> phase != $past(phase)) else $error("strobe not toggling");
	AST_PD_REF: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		pd_req |=> !REFERENCE_ON_O && !INTERNAL_CLOCK_ON_O)
		else $error("reference or clock left on in power-down");
	AST_STBY_REF: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		state == ADCOF_DOWN && !pd_req |=> REFERENCE_ON_O)
		else $error("reference off in standby");
	// Samples taken while down must never reach the buffer
	AST_DROP: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		SAMPLE_VALID_I && state != ADCOF_RUN |-> ##11 !vld_d)
		else $error("sample kept while down");
	AST_LATENCY: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		SAMPLE_VALID_I && state == ADCOF_RUN && cnt == 2'h0 && RECV_READY_I
		|-> ##11 vld_d) else $error("sample latency wrong");
	AST_SAT: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		OVER_HIGH_I |-> sat_code == ADCOF_CODE_MAX) else $error("no saturation");
	AST_WAKE: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		state == ADCOF_DOWN && !pd_req && !SERIAL_STANDBY_I |=> state == ADCOF_WAKE)
		else $error("no wake on pin low");
	COV_PD: cover property (@(posedge MCLK_I) state == ADCOF_DOWN ##1 state == ADCOF_WAKE);
	COV_LOCK: cover property (@(posedge MCLK_I) $rose(locked));
	COV_FULL: cover property (@(posedge MCLK_I) cnt == 2'h2);
	COV_STANDBY: cover property (@(posedge MCLK_I) state == ADCOF_DOWN && !pd_req);
	COV_GRAY: cover property (@(posedge MCLK_I) SAMPLE_VALID_I && fmt == ADCOF_FMT_GRAY);
endmodule

/* File: dv/adcof_capture.sv */
// Capture register model standing behind the data outputs
`timescale 1ns/1ns
module adcof_capture import adcof_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [11:0] data_i,
	input wire logic over_i,
	input wire logic [1:0] dco_i,
	input wire logic invert_i,
	input wire logic stall_i,
	output logic ready_o
);
	logic [12:0] words[$];
	// Stall drops ready so the buffer must hold words
	assign ready_o = !stall_i;
	// ****************************************
	// Latch at each clock edge while the data clock is active
	// ****************************************
	always @(posedge clk_i) begin
		if (reset_i) begin
			words.delete();
		end else if ((dco_i[0] ^ invert_i) === 1'b1) begin
			words.push_back({over_i, data_i});
		end
	end
endmodule

/* File: dv/test_adc_output_formatter.sv */
// Self-checking bench for the output formatter
`timescale 1ns/1ns
module test_adc_output_formatter import adcof_pkg::*; ();
	localparam int RC = 8;
	logic clk = 0, rst = 1, vld = 0, smode = 0, fpin = 0, spin = 0, sstab = 0, rchg = 0;
	logic pdp = 0, spd = 0, sstby = 0, odp = 0, inv = 0, hi = 0, lo = 0, stall = 0, rdy, slow = 0;
	logic [11:0] smp = 0;
	logic [1:0] sfmt = 0, odb = 0, fdb = 0, fsel;
	logic [2:0] div = 0;
	logic [11:0] da, db;
	logic ovr, dv, sact, slock, refon, iclk, pdn, bufr;
	logic [1:0] doe, foe, data_output_clock;
	logic [12:0] wd;
	logic [13:0] tbl [6] = '{14'h0000, 14'h0800, 14'h0fff, 14'h05a3, 14'h2123, 14'h1123};
	int errors = 0, num_checks = 0, lat, w1, w2;
	adcof_top #(.RELOCK_CYC(RC)) dut_u (.MCLK_I(clk), .RESET_I(rst), .SAMPLE_I(smp),
		.OVER_HIGH_I(hi), .OVER_LOW_I(lo), .SAMPLE_VALID_I(vld), .SERIAL_MODE_I(smode),
		.FORMAT_SELECT_PIN_I(fpin), .STABILIZER_SELECT_PIN_I(spin), .SERIAL_FORMAT_I(sfmt),
		.SERIAL_STABILIZER_I(sstab), .CLOCK_DIVIDER_I(div), .RATE_CHANGE_I(rchg),
		.SLOW_CLOCK_I(slow), .POWER_DOWN_PIN_I(pdp), .SERIAL_POWER_DOWN_I(spd),
		.SERIAL_STANDBY_I(sstby), .OUTPUT_DISABLE_PIN_I(odp), .OUTPUT_DISABLE_BIT_I(odb),
		.FAST_DISABLE_BIT_I(fdb), .DCO_INVERT_I(inv), .RECV_READY_I(rdy), .DATA_A_O(da),
		.DATA_B_O(db), .OVERRANGE_O(ovr), .DATA_OE_O(doe), .FAST_OE_O(foe),
		.DATA_VALID_O(dv), .DATA_OUTPUT_CLOCK_O(data_output_clock), .STABILIZER_ACTIVE_O(sact),
		.STABILIZER_LOCKED_O(slock), .REFERENCE_ON_O(refon), .INTERNAL_CLOCK_ON_O(iclk),
		.POWERED_DOWN_O(pdn), .BUF_READY_O(bufr));
	adcof_capture cap_u (.clk_i(clk), .reset_i(rst), .data_i(da), .over_i(ovr), .dco_i(data_output_clock),
		.invert_i(inv), .stall_i(stall), .ready_o(rdy));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Ends two ns past an edge, where inputs change and outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	function automatic logic [11:0] code(input logic [11:0] ob, input logic [1:0] f);
		if (f == 2'h1) return ob ^ ADCOF_MSB;
		if (f == 2'h2) return ob ^ (ob >> 1);
		return ob;
	endfunction
	task automatic xfer(input logic [11:0] s, input logic h, input logic l, input logic [1:0] f);
		logic [11:0] sat;
		sat = h ? ADCOF_CODE_MAX : (l ? ADCOF_CODE_MIN : s);
		smp = s;
		hi = h;
		lo = l;
		vld = 1;
		cyc(1);
		vld = 0;
		hi = 0;
		lo = 0;
		lat = 0;
		while (dv !== 1'b1 && lat < 40) begin
			cyc(1);
			lat++;
		end
		chk("latency", 13'd12, 13'(lat));
		chk("lane b", {1'b0, code(s, f)}, {1'b0, db});
		cyc(1);
		wd = cap_u.words.size() > 0 ? cap_u.words.pop_front() : 13'h1fff;
		chk("word", {h | l, code(sat, f)}, wd);
	endtask
	// Bounded wait for the device to leave its down state
	task automatic wake(output int n);
		n = 0;
		while (pdn !== 1'b0 && n < 300) begin
			cyc(1);
			n++;
		end
		chk("awake", 13'h0, {12'h0, pdn});
	endtask
	task automatic burst(input int n);
		vld = 1;
		for (int i = 1; i <= n; i++) begin
			smp = 12'(i);
			cyc(1);
		end
		vld = 0;
		cyc(16);
	endtask
	task automatic conclude();
		$display("Checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		forever #10 clk = ~clk;
	end
	initial begin
		#100000;
		errors++;
		conclude();
	end
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		cyc(4);
		rst = 0;
		chk("reset ref", 13'h3, {11'h0, refon, iclk});
		chk("reset valid", 13'h0, {12'h0, dv});
		// Pin modes, then every serial format
		for (int m = 0; m < 5; m++) begin
			smode = (m >= 2);
			fpin = (m == 1);
			sfmt = (m >= 2) ? 2'(m - 2) : 2'h0;
			fsel = smode ? sfmt : {1'b0, fpin};
			foreach (tbl[k]) begin
				xfer(tbl[k][11:0], tbl[k][13], tbl[k][12], fsel);
			end
		end
		smode = 0;
		fpin = 0;
		$display("Test formats done");
		// Stalled receiver: two words kept, the third dropped
		stall = 1;
		burst(3);
		chk("buf ready", 13'h0, {12'h0, bufr});
		chk("held", 13'h0, 13'(cap_u.words.size()));
		stall = 0;
		cyc(8);
		chk("drained", 13'h2, 13'(cap_u.words.size()));
		chk("first", 13'h001, cap_u.words.pop_front());
		chk("second", 13'h002, cap_u.words.pop_front());
		burst(3);
		chk("back to back", 13'h3, 13'(cap_u.words.size()));
		for (int i = 1; i <= 3; i++) begin
			chk("order", 13'(i), cap_u.words.pop_front());
		end
		cap_u.words.delete();
		$display("Test buffer done");
		odp = 1;
		cyc(2);
		chk("pin off", 13'h0, {11'h0, doe});
		odp = 0;
		cyc(2);
		chk("pin on", 13'h3, {11'h0, doe});
		smode = 1;
		odb = 2'b01;
		fdb = 2'b10;
		cyc(2);
		chk("bit data", 13'h2, {11'h0, doe});
		chk("bit fast", 13'h1, {11'h0, foe});
		odb = 0;
		fdb = 0;
		smode = 0;
		$display("Test disable done");
		pdp = 1;
		cyc(2);
		chk("down", 13'h1, {12'h0, pdn});
		chk("down oe", 13'h0, {11'h0, doe});
		chk("down ref clk", 13'h0, {11'h0, refon, iclk});
		vld = 1;
		cyc(1);
		vld = 0;
		cyc(7);
		pdp = 0;
		wake(w1);
		chk("dropped", 13'h0, 13'(cap_u.words.size()));
		pdp = 1;
		cyc(30);
		pdp = 0;
		wake(w2);
		chk("wake grows", 13'h1, {12'h0, w2 > w1});
		xfer(12'h3c5, 0, 0, 2'h0);
		smode = 1;
		spd = 1;
		cyc(2);
		chk("serial down", 13'h1, {12'h0, pdn});
		spd = 0;
		wake(w1);
		sstby = 1;
		cyc(2);
		chk("standby", 13'h3, {11'h0, pdn, refon});
		cyc(30);
		sstby = 0;
		wake(w1);
		chk("standby faster", 13'h1, {12'h0, w1 < w2});
		smode = 0;
		$display("Test power done");
		spin = 1;
		cyc(2);
		chk("stab pin", 13'h1, {12'h0, sact});
		spin = 0;
		div = 3'h3;
		cyc(2);
		chk("stab divider", 13'h1, {12'h0, sact});
		div = ADCOF_DIV_ONE;
		spin = 1;
		cyc(RC + 4);
		rchg = 1;
		cyc(2);
		rchg = 0;
		chk("bypassed", 13'h0, {12'h0, slock});
		cyc(RC + 4);
		chk("relocked", 13'h1, {12'h0, slock});
		slow = 1;
		cyc(2);
		chk("slow idle", 13'h0, {11'h0, sact, slock});
		slow = 0;
		spin = 0;
		smode = 1;
		sstab = 1;
		cyc(2);
		chk("stab serial", 13'h1, {12'h0, sact});
		sstab = 0;
		smode = 0;
		$display("Test stabilizer done");
		inv = 1;
		cyc(3);
		chk("dco idle", 13'h3, {11'h0, data_output_clock});
		cap_u.words.delete();
		xfer(12'h321, 0, 0, 2'h0);
		$display("Test data clock done");
		conclude();
	end
endmodule
